// ---- rtl/vrc_regs.svh ----
`ifndef VRC_REGS_SVH
`define VRC_REGS_SVH

// Controller clock period in ns
`define VRC_CLK_NS 40
// Page-mode column strobe fall-to-fall spacing in ns
`define VRC_PAGE_SPACE_NS 100
`define VRC_PAGE_SPACE_STR_NS 150
// Refresh strobe low time in ns
`define VRC_REF_LOW_NS 100
`define VRC_REF_LOW_STR_NS 150
// Least times round up to whole cycles
`define VRC_CEIL_CYC(ns) (((ns) + `VRC_CLK_NS - 1) / `VRC_CLK_NS)
`define VRC_PAGE_CYC 3'(`VRC_CEIL_CYC(`VRC_PAGE_SPACE_NS))
`define VRC_PAGE_CYC_STR 3'(`VRC_CEIL_CYC(`VRC_PAGE_SPACE_STR_NS))
`define VRC_REF_CYC 3'(`VRC_CEIL_CYC(`VRC_REF_LOW_NS))
`define VRC_REF_CYC_STR 3'(`VRC_CEIL_CYC(`VRC_REF_LOW_STR_NS))
// Row strobe fall-to-fall spacing in clock cycles
`define VRC_RAS_CYC 4'h5
`define VRC_RAS_CYC_PRE 4'h6
`define VRC_RAS_CYC_BOTH 4'h7
// Default refresh interval in clock cycles
`define VRC_REF_INTERVAL 390

`endif

// ---- rtl/vrc_pkg.sv ----
package vrc_pkg;

	// Memory configuration bits, ordered as the configuration byte
	typedef struct packed {
		logic refresh_active_stretch;
		logic row_precharge_stretch;
		logic page_cycle_stretch;
	} vrc_cfg_s;

	// One access request from the internal access source
	typedef struct packed {
		logic write;
		logic paged;
		logic [8:0] row;
		logic [8:0] col;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} vrc_req_s;

	// Cycle sequencer states
	typedef enum logic [2:0] {
		VRC_IDLE = 3'h0,
		VRC_ROW = 3'h1,
		VRC_COL_LOW = 3'h2,
		VRC_COL_HIGH = 3'h3,
		VRC_REF_COL = 3'h4,
		VRC_REF_BOTH = 3'h5
	} vrc_state_e;

endpackage

// ---- rtl/vrc_ctrl.sv ----
`timescale 1ns/10ps
`include "vrc_regs.svh"
module vrc_ctrl #(
	parameter int REF_INTERVAL = `VRC_REF_INTERVAL
) (
	input wire logic clk,
	input wire logic rst,
	input wire vrc_pkg::vrc_cfg_s cfg,
	input wire logic narrow_width,
	input wire logic req_valid,
	input wire vrc_pkg::vrc_req_s req,
	output logic req_ready,
	output logic [31:0] rd_data,
	output logic rd_valid,
	output logic vram_row_strobe_n,
	output logic vram_column_strobe_n,
	output logic vram_output_enable_n,
	output logic [3:0] vram_byte_write_enable_n,
	output logic [8:0] vram_muxed_address,
	input wire logic [31:0] vram_data_in,
	output logic [31:0] vram_data_out,
	output logic vram_data_oe
);

	// Sequencer state and its next value
	vrc_pkg::vrc_state_e state_reg, state_next;
	// Cycles since the last row strobe fall, saturating, and the spacing that fall owes
	logic [3:0] cyc_reg, cyc_next, ras_last_reg;
	// Cycles spent in the current strobe phase
	logic [2:0] sub_reg, sub_next;
	// Current column beat and the last beat of the access
	logic [1:0] beat_reg, beat_next, last_reg;
	// Request and configuration held for the whole cycle
	vrc_pkg::vrc_req_s cur_reg;
	vrc_pkg::vrc_cfg_s cfg_reg;
	logic narrow_reg;
	// Refresh timer and pending flag
	logic [9:0] ref_cnt_reg;
	logic ref_pend_reg, ref_pend_next;
	// Two-stage synchroniser for the memory data pins
	logic [31:0] din_meta_reg, din_sync_reg;

	// Timing figures selected by the latched configuration
	wire [2:0] page_cyc = cfg_reg.page_cycle_stretch ? `VRC_PAGE_CYC_STR : `VRC_PAGE_CYC;
	wire [2:0] ref_cyc = cfg_reg.refresh_active_stretch ? `VRC_REF_CYC_STR : `VRC_REF_CYC;
	wire [3:0] ras_cyc = !cfg_reg.row_precharge_stretch ? `VRC_RAS_CYC :
		(cfg_reg.page_cycle_stretch ? `VRC_RAS_CYC_BOTH : `VRC_RAS_CYC_PRE);
	wire [3:0] ras_need = (ras_last_reg > ras_cyc) ? ras_last_reg : ras_cyc; // Survives a change
	// Next row strobe fall may land on the coming edge; widened so 4'hf does not wrap
	wire gap_ok = ({1'b0, cyc_reg} + 5'h01) >= {1'b0, ras_need};
	wire ref_tick = ref_cnt_reg == 10'h0;
	wire take = (state_reg == vrc_pkg::VRC_IDLE) && req_valid && req_ready;
	wire [1:0] base_beats = narrow_width ? 2'h1 : 2'h0;
	wire [1:0] req_last = req.paged ? {base_beats[0], 1'b1} : base_beats;
	wire is_last = beat_reg == last_reg;

	// Sequencer next-state decode
	always_comb begin
		state_next = state_reg;
		sub_next = sub_reg + 3'h1;
		beat_next = beat_reg;
		case (state_reg)
			vrc_pkg::VRC_IDLE: begin
				sub_next = 3'h0;
				beat_next = 2'h0;
				if (ref_pend_reg && gap_ok) begin
					state_next = vrc_pkg::VRC_REF_COL;
				end else if (take) begin
					state_next = vrc_pkg::VRC_ROW;
				end
			end
			vrc_pkg::VRC_ROW: begin
				state_next = vrc_pkg::VRC_COL_LOW;
				sub_next = 3'h0;
			end
			vrc_pkg::VRC_COL_LOW: begin
				// low for all but one cycle of spacing
				if (sub_reg == page_cyc - 3'h2) begin
					state_next = vrc_pkg::VRC_COL_HIGH;
				end
			end
			vrc_pkg::VRC_COL_HIGH: begin
				sub_next = 3'h0;
				beat_next = beat_reg + 2'h1;
				// further beats stay in the open page
				if (is_last) begin
					state_next = vrc_pkg::VRC_IDLE;
				end else begin
					state_next = vrc_pkg::VRC_COL_LOW;
				end
			end
			vrc_pkg::VRC_REF_COL: begin
				state_next = vrc_pkg::VRC_REF_BOTH;
				sub_next = 3'h0;
			end
			vrc_pkg::VRC_REF_BOTH: begin
				// both strobes low for the refresh time
				if (sub_reg == ref_cyc - 3'h1) begin
					state_next = vrc_pkg::VRC_IDLE;
				end
			end
			default: begin
				state_next = vrc_pkg::VRC_IDLE;
			end
		endcase
	end

	// Strobe levels for the coming cycle
	wire ras_on_next = (state_next == vrc_pkg::VRC_ROW) || (state_next == vrc_pkg::VRC_COL_LOW)
		|| (state_next == vrc_pkg::VRC_REF_BOTH)
		|| ((state_next == vrc_pkg::VRC_COL_HIGH) && (beat_next != last_reg));
	// column strobe leads the row strobe in refresh
	wire cas_on_next = (state_next == vrc_pkg::VRC_COL_LOW) ||
		(state_next == vrc_pkg::VRC_REF_COL) || (state_next == vrc_pkg::VRC_REF_BOTH);
	wire col_next = state_next == vrc_pkg::VRC_COL_LOW;
	wire ras_fall = ras_on_next && vram_row_strobe_n;
	// Request used for the coming cycle, fresh when just taken
	wire vrc_pkg::vrc_req_s req_use = take ? req : cur_reg;
	wire narrow_use = take ? narrow_width : narrow_reg;
	wire [8:0] col_addr = req_use.col + {7'h0, beat_next};
	// Narrow memory carries halves on the low lanes, low half first
	wire hi_half = narrow_use && beat_next[0];
	wire [31:0] wdata_next = hi_half ? {16'h0, req_use.wdata[31:16]} : req_use.wdata;
	wire [3:0] be_next = narrow_use ? (hi_half ? {2'h0, req_use.byte_en[3:2]} :
		{2'h0, req_use.byte_en[1:0]}) : req_use.byte_en;
	wire [9:0] ref_cnt_next = ref_tick ? 10'(REF_INTERVAL - 1) : ref_cnt_reg - 10'h1;
	// Cycles counted to the next edge for the ready decision
	assign cyc_next = ras_fall ? 4'h0 : ((cyc_reg == 4'hf) ? cyc_reg : cyc_reg + 4'h1);
	// Tick sets the flag and wins over the clear on refresh entry
	assign ref_pend_next = ref_tick || (ref_pend_reg && (state_next != vrc_pkg::VRC_REF_COL));
	wire ready_next = (state_next == vrc_pkg::VRC_IDLE) && !ref_pend_next &&
		(({1'b0, cyc_next} + 5'h01) >= {1'b0, ras_need});
	// capture on the cycle the column strobe deasserts
	wire capture = (state_reg == vrc_pkg::VRC_COL_HIGH) && !cur_reg.write;

	// Sequencer registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= vrc_pkg::VRC_IDLE;
			sub_reg <= 3'h0;
			beat_reg <= 2'h0;
			cyc_reg <= 4'hf;
			ras_last_reg <= `VRC_RAS_CYC;
		end else begin
			state_reg <= state_next;
			sub_reg <= sub_next;
			beat_reg <= beat_next;
			cyc_reg <= cyc_next;
			// Setting is frozen while a cycle runs, so this is what its fall owes
			if (state_reg != vrc_pkg::VRC_IDLE) begin
				ras_last_reg <= ras_cyc;
			end
		end
	end

	// Request and configuration latched as a cycle starts
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur_reg <= '0;
			cfg_reg <= '0;
			narrow_reg <= 1'b0;
			last_reg <= 2'h0;
		end else if (state_reg == vrc_pkg::VRC_IDLE) begin
			cfg_reg <= cfg;
			if (take) begin
				cur_reg <= req;
				narrow_reg <= narrow_width;
				last_reg <= req_last;
			end else begin
				last_reg <= 2'h0;
			end
		end
	end

	// periodic refresh request, held until served
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ref_cnt_reg <= 10'(REF_INTERVAL - 1);
			ref_pend_reg <= 1'b0;
			req_ready <= 1'b0;
		end else begin
			ref_cnt_reg <= ref_cnt_next;
			ref_pend_reg <= ref_pend_next;
			req_ready <= ready_next;
		end
	end

	// every memory pin is a flop on clk
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vram_row_strobe_n <= 1'b1;
			vram_column_strobe_n <= 1'b1;
			vram_output_enable_n <= 1'b1;
			vram_byte_write_enable_n <= 4'hf;
			vram_muxed_address <= 9'h0;
			vram_data_out <= 32'h0;
			vram_data_oe <= 1'b0;
		end else begin
			vram_row_strobe_n <= !ras_on_next;
			vram_column_strobe_n <= !cas_on_next;
			vram_output_enable_n <= !(col_next && !req_use.write);
			vram_byte_write_enable_n <= (col_next && req_use.write) ? ~be_next : 4'hf;
			vram_data_oe <= col_next && req_use.write;
			vram_data_out <= wdata_next;
			if (state_next == vrc_pkg::VRC_ROW) begin
				vram_muxed_address <= req_use.row;
			end else if (col_next) begin
				vram_muxed_address <= col_addr;
			end
		end
	end

	// Data pins are outside this clock, so they pass two flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			din_meta_reg <= 32'h0;
			din_sync_reg <= 32'h0;
		end else begin
			din_meta_reg <= vram_data_in;
			din_sync_reg <= din_meta_reg;
		end
	end

	// read word assembly, one valid per full word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= 32'h0;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= capture && (!narrow_reg || beat_reg[0]);
			if (capture && narrow_reg && !beat_reg[0]) begin
				rd_data[15:0] <= din_sync_reg[15:0];
			end else if (capture && narrow_reg) begin
				rd_data[31:16] <= din_sync_reg[15:0];
			end else if (capture) begin
				rd_data <= din_sync_reg;
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// Refresh start: row strobe falls while column strobe already low
	sequence ref_start;
		$fell(vram_row_strobe_n) && !vram_column_strobe_n;
	endsequence
	// Access column fall inside an open row
	sequence col_start;
		$fell(vram_column_strobe_n) && !vram_row_strobe_n;
	endsequence

	a_addr_stable: assert property (!vram_column_strobe_n && $past(!vram_column_strobe_n)
		|-> $stable(vram_muxed_address)) else $error("address moved under column strobe");
	a_read_capture: assert property (rd_valid |-> $past(vram_column_strobe_n) &&
		!$past(vram_column_strobe_n, 2)) else $error("read word not at strobe rise");
	a_narrow_page: assert property ((state_reg == vrc_pkg::VRC_COL_HIGH) && narrow_reg &&
		!beat_reg[0] |=> !vram_column_strobe_n && !vram_row_strobe_n)
		else $error("narrow access lacks second beat");
	a_paged_page: assert property ((state_reg == vrc_pkg::VRC_COL_HIGH) && cur_reg.paged &&
		(beat_reg == 2'h0) |=> !vram_column_strobe_n) else $error("paged access not paged");
	a_refresh_order: assert property (ref_start |-> $past(!vram_column_strobe_n) &&
		$stable(vram_muxed_address)) else $error("refresh order wrong");
	a_refresh_short: assert property ((ref_start and !cfg_reg.refresh_active_stretch) |->
		(!vram_row_strobe_n)[*3] ##1 vram_row_strobe_n) else $error("refresh low not 100ns");
	a_refresh_long: assert property ((ref_start and cfg_reg.refresh_active_stretch) |->
		(!vram_row_strobe_n && !vram_column_strobe_n)[*4] ##1 vram_row_strobe_n)
		else $error("refresh low not 150ns");
	a_col_short: assert property ((col_start and !cfg_reg.page_cycle_stretch) |->
		(!vram_column_strobe_n)[*2] ##1 vram_column_strobe_n) else $error("column timing wrong");
	a_col_long: assert property ((col_start and cfg_reg.page_cycle_stretch) |->
		(!vram_column_strobe_n)[*3] ##1 vram_column_strobe_n) else $error("column stretch wrong");
	a_ras_spacing: assert property ($fell(vram_row_strobe_n) && !cfg_reg.row_precharge_stretch
		|=> (!$fell(vram_row_strobe_n))[*4]) else $error("row strobes too close");
	a_ras_both: assert property ($fell(vram_row_strobe_n) && cfg_reg.row_precharge_stretch &&
		cfg_reg.page_cycle_stretch |=> (!$fell(vram_row_strobe_n))[*6])
		else $error("row strobes too close, both stretched");
	a_no_cut: assert property ($fell(vram_column_strobe_n) && vram_row_strobe_n |->
		$past(vram_row_strobe_n) && $past(vram_row_strobe_n, 2))
		else $error("refresh cut an access");

endmodule

// ---- tb/vrc_vram_model.sv ----
`timescale 1ns/10ps
// Behavioural VRAM random port: latches row and column on strobe falls
module vrc_vram_model (
	input wire logic clk,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic oe_n,
	input wire logic [3:0] we_n,
	input wire logic [8:0] addr,
	input wire logic [31:0] dout,
	input wire logic data_oe,
	output logic [31:0] din
);
	// Small array, only the low address bits are decoded
	logic [31:0] mem [0:1023];
	logic [8:0] row = '0;
	logic [8:0] col = '0;
	logic [31:0] last = '0;
	logic ras_p = 1'b1;
	logic cas_p = 1'b1;
	wire rd_on = !oe_n && !cas_n && !ras_n;
	// Released bus shows the inverse of the last value, never a stale match
	assign din = rd_on ? mem[{row[4:0], col[4:0]}] : ~last;
	// Strobes are registered, so sample them in mid-cycle
	always @(negedge clk) begin
		if (ras_p && !ras_n && cas_n) begin
			row = addr;
		end
		if (cas_p && !cas_n && !ras_n) begin
			col = addr;
		end
		for (int b = 0; b < 4; b++) begin
			if (!ras_n && !cas_n && !we_n[b] && data_oe) begin
				mem[{row[4:0], col[4:0]}][b*8 +: 8] = dout[b*8 +: 8];
			end
		end
		if (rd_on) begin
			last = din;
		end
		ras_p = ras_n;
		cas_p = cas_n;
	end
endmodule

// ---- tb/vrc_ctrl_bench.sv ----
`timescale 1ns/10ps
// Self-checking bench for the VRAM cycle controller
module vrc_ctrl_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	vrc_pkg::vrc_cfg_s cfg = '0;
	logic narrow_width = 1'b0;
	logic req_valid = 1'b0;
	vrc_pkg::vrc_req_s req = '0;
	logic req_ready, rd_valid, ras_n, cas_n, oe_n, data_oe;
	logic [31:0] rd_data, din, dout;
	logic [3:0] we_n;
	logic [8:0] addr;
	logic [8:0] addr_p = '0;
	logic ras_p = 1'b1;
	logic cas_p = 1'b1;
	logic ref_mode = 1'b0;
	logic addr_moved = 1'b0;
	int err_count = 0;
	int compares = 0;
	int cyc = 0, ras_t = 0, cas_t = 0, ras_gap = 0, cas_gap = 0;
	int cas_cnt = 0, ref_cnt = 0, ref_len = 0, refs = 0;

	// 25 MHz clock
	always #20 clk = ~clk;

	// Short refresh interval keeps the run brief
	vrc_ctrl #(.REF_INTERVAL(40)) uut (.clk(clk), .rst(rst), .cfg(cfg),
		.narrow_width(narrow_width), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
		.vram_row_strobe_n(ras_n), .vram_column_strobe_n(cas_n),
		.vram_output_enable_n(oe_n), .vram_byte_write_enable_n(we_n),
		.vram_muxed_address(addr), .vram_data_in(din), .vram_data_out(dout),
		.vram_data_oe(data_oe));

	vrc_vram_model vram (.clk(clk), .ras_n(ras_n), .cas_n(cas_n), .oe_n(oe_n),
		.we_n(we_n), .addr(addr), .dout(dout), .data_oe(data_oe), .din(din));

	// Strobe monitor: gaps, column strobes per row cycle, refresh length
	always @(negedge clk) begin
		cyc++;
		if (ras_p && !ras_n) begin
			ras_gap = cyc - ras_t;
			ras_t = cyc;
			cas_cnt = 0;
			ref_cnt = 0;
			ref_mode = !cas_n;
			addr_moved = 1'b0;
		end
		if (cas_p && !cas_n && !ras_n) begin
			cas_gap = cyc - cas_t;
			cas_t = cyc;
			cas_cnt++;
		end
		if (ref_mode && !ras_n) begin
			ref_cnt++;
			if (addr !== addr_p) addr_moved = 1'b1;
		end
		if (!ras_p && ras_n && ref_mode) begin
			ref_len = ref_cnt;
			refs++;
			ref_mode = 1'b0;
		end
		ras_p = ras_n;
		cas_p = cas_n;
		addr_p = addr;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask

	task automatic end_sim();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// A wait that ran out counts as a mismatch and ends the run
	task automatic hang();
		chk(32'h0, 32'h1);
		end_sim();
	endtask

	// Request held until the edge where ready is seen high
	task automatic do_req(input logic w, input logic p, input logic [8:0] r,
		input logic [8:0] c, input logic [31:0] d);
		int i;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{write: w, paged: p, row: r, col: c, byte_en: 4'hf, wdata: d};
		for (i = 0; i < 300; i++) begin
			@(posedge clk);
			if (req_ready === 1'b1) break;
		end
		req_valid <= 1'b0;
		if (i == 300) hang();
	endtask

	task automatic wait_rd(input logic [31:0] exp);
		int i;
		for (i = 0; i < 100; i++) begin
			@(posedge clk);
			if (rd_valid === 1'b1) break;
		end
		if (i == 100) hang();
		chk(rd_data, exp);
	endtask

	// Back-to-back write and read under each row spacing setting
	task automatic t_rows();
		int r;
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			cfg <= (k == 0) ? 3'b000 : (k == 1) ? 3'b010 : 3'b011;
			r = refs;
			do_req(1'b1, 1'b0, 9'(k), 9'h004, 32'h1234_5600 + k);
			do_req(1'b0, 1'b0, 9'(k), 9'h004, 32'h0);
			wait_rd(32'h1234_5600 + k);
			if (refs == r) chk(ras_gap, 5 + k);
		end
		$display("done t_rows");
	endtask

	// Paged read of two words with and without page stretch
	task automatic t_page(input logic va);
		@(posedge clk);
		cfg <= {2'b00, va};
		do_req(1'b1, 1'b0, 9'h009, 9'h008, 32'ha5a5_0001);
		do_req(1'b1, 1'b0, 9'h009, 9'h009, 32'h5a5a_0002);
		do_req(1'b0, 1'b1, 9'h009, 9'h008, 32'h0);
		wait_rd(32'ha5a5_0001);
		wait_rd(32'h5a5a_0002);
		chk(cas_cnt, 2);
		chk(cas_gap, va ? 4 : 3);
		$display("done t_page");
	endtask

	// Half-width memory needs two column strobes per word
	task automatic t_narrow();
		@(posedge clk);
		narrow_width <= 1'b1;
		do_req(1'b1, 1'b0, 9'h003, 9'h002, 32'hbeef_cafe);
		do_req(1'b0, 1'b0, 9'h003, 9'h002, 32'h0);
		wait_rd(32'hbeef_cafe);
		chk(cas_cnt, 2);
		narrow_width <= 1'b0;
		$display("done t_narrow");
	endtask

	// Second refresh after the change runs wholly under the new setting
	task automatic t_ref(input logic ra);
		int r;
		int i;
		@(posedge clk);
		cfg <= {ra, 2'b00};
		r = refs + 2;
		for (i = 0; i < 300 && refs < r; i++) @(posedge clk);
		if (i == 300) hang();
		chk(ref_len, ra ? 4 : 3);
		chk(addr_moved, 1'b0);
		$display("done t_ref");
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_rows();
		t_page(1'b0);
		t_page(1'b1);
		t_narrow();
		t_ref(1'b0);
		t_ref(1'b1);
		end_sim();
	end
endmodule
